// [dlsp_top.sv]
// Operation
// - forward symbol is 35 bits per clock
// - recovered clock range per lane mode
// - serial line rate limits per lane mode
// - lock without reference clock or training
// - back channel sent as serial frames
// - frame holds i2c, crc, four gpio bits
// - control channel bridges i2c across link
// - port select bits steer duplicated registers
// - reads return selected port, second wins
// - writes update every selected port copy
// - power-up starts recovery, lock driven regardless of enable
// - lock goes high after lock sequence
// - outputs follow pin, enable and sleep bits
// - enable and sleep high: static or valid
// - fast gpio float when enable low sleep high or single lane
// - remote interrupt active low, forwarded
// - fast gpio work only in dual lane
// - high-speed bit forces 20 Mbps back channel
`timescale 1ns/100ps
`include "dlsp_consts.svh"

module dlsp_top (
  input  wire logic        CLK,
  input  wire logic        RST_N,
  input  wire logic        POWER_DOWN_N,
  input  wire logic        STRAP_SELECT_B,
  input  wire logic        DUAL_LANE,
  input  wire logic        LINK_CLK,
  input  wire logic        LINK_DATA,
  input  wire logic        REMOTE_IRQ_IN_N,
  input  wire logic [3:0]  BC_GPIO_IN,
  input  wire logic        SCL_IN,
  input  wire logic        SDA_IN,
  output logic             SDA_OE,
  output logic             BC_TX,
  output logic             LOCK,
  output logic             LOCK_OE,
  output logic             PASS,
  output logic             PASS_OE,
  output logic [3:0]       D_GPIO,
  output logic [3:0]       D_GPIO_OE,
  output logic             CSI_HS_ZERO,
  output logic             CSI_OE,
  output dlsp_pkg::dlsp_sym_t FWD_DATA,
  output logic             FWD_VALID,
  input  wire logic        FWD_READY
);

  // crc-4 over the back-channel payload, polynomial x^4 + x + 1
  function automatic logic [3:0] crc4(input logic [5:0] din);
    logic [3:0] c;
    c = 4'h0;
    for (int i = 5; i >= 0; i--) begin
      c = {c[2:0], 1'b0} ^ ((c[3] ^ din[i]) ? 4'h3 : 4'h0);
    end
    return c;
  endfunction : crc4

  // two-flop synchronisers for every pin input except RST_N and FWD_READY
  logic [7:0]  meta_q, sync_q;
  logic [3:0]  bcg_meta_q, bcg_sync_q;
  always_ff @(posedge CLK) begin
    meta_q     <= {POWER_DOWN_N, STRAP_SELECT_B, DUAL_LANE, LINK_CLK, LINK_DATA,
                   REMOTE_IRQ_IN_N, SCL_IN, SDA_IN};
    sync_q     <= meta_q;
    bcg_meta_q <= BC_GPIO_IN;
    bcg_sync_q <= bcg_meta_q;
  end
  logic pd_n, strap_b, dual, lclk, ldat, irq_n, scl, sda;
  assign {pd_n, strap_b, dual, lclk, ldat, irq_n, scl, sda} = sync_q;

  // power-down acts as a reset of all link-facing logic
  logic run;
  assign run = RST_N & pd_n;

  // edge history, taken from the second flop only
  logic lclk_q, scl_q, sda_q, irq_q;
  always_ff @(posedge CLK) begin
    lclk_q <= lclk;
    scl_q  <= scl;
    sda_q  <= sda;
    irq_q  <= irq_n;
  end
  logic lclk_rise, scl_rise, scl_fall, i2c_start, i2c_stop;
  assign lclk_rise = lclk & ~lclk_q;
  assign scl_rise  = scl & ~scl_q;
  assign scl_fall  = ~scl & scl_q;
  assign i2c_start = scl & scl_q & sda_q & ~sda;
  assign i2c_stop  = scl & scl_q & ~sda_q & sda;

  // registers
  logic [7:0] out_cfg_q, port_sel_q, bc_cfg_q, irq_cfg_q;
  logic [7:0] port_gpio_q [2];
  logic       wr_en;
  logic [7:0] wr_addr, wr_data;
  logic       lock_q, irq_pend_q, ovf_q;
  logic       strap_seen_q;

  // strap is caught on the first cycle after reset release
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      out_cfg_q      <= `DLSP_OUT_CFG_RST;
      port_sel_q     <= `DLSP_PORT_SEL_RST;
      bc_cfg_q       <= `DLSP_BC_CFG_RST;
      irq_cfg_q      <= `DLSP_IRQ_CFG_RST;
      port_gpio_q[0] <= `DLSP_PORT_GPIO_RST;
      port_gpio_q[1] <= `DLSP_PORT_GPIO_RST;
      strap_seen_q   <= 1'b0;
    end else begin
      strap_seen_q <= 1'b1;
      if (!strap_seen_q) begin
        bc_cfg_q[`DLSP_BC_HS_BIT] <= strap_b;
      end else if (wr_en) begin
        case (wr_addr)
          `DLSP_REG_OUT_CFG:  out_cfg_q  <= wr_data;
          `DLSP_REG_BC_CFG:   bc_cfg_q   <= wr_data;
          `DLSP_REG_PORT_SEL: port_sel_q <= wr_data;
          `DLSP_REG_IRQ_CFG:  irq_cfg_q  <= wr_data;
          `DLSP_REG_PORT_GPIO: begin
            if (port_sel_q[`DLSP_FIRST_PORT_BIT]) begin
              port_gpio_q[0] <= wr_data;
            end
            if (port_sel_q[`DLSP_SECOND_PORT_BIT]) begin
              port_gpio_q[1] <= wr_data;
            end
          end
          default: ;
        endcase
      end
    end
  end

  // read decode; shared registers ignore the port select
  function automatic logic [7:0] rd_mux(input logic [7:0] a);
    case (a)
      `DLSP_REG_OUT_CFG:   rd_mux = out_cfg_q;
      `DLSP_REG_BC_CFG:    rd_mux = bc_cfg_q;
      `DLSP_REG_PORT_SEL:  rd_mux = port_sel_q;
      `DLSP_REG_IRQ_CFG:   rd_mux = irq_cfg_q;
      `DLSP_REG_STATUS:    rd_mux = {4'h0, ovf_q, irq_pend_q, dual, lock_q};
      `DLSP_REG_PORT_GPIO: rd_mux = port_sel_q[`DLSP_SECOND_PORT_BIT] ?
                                    port_gpio_q[1] : port_gpio_q[0];
      default:             rd_mux = 8'h00;
    endcase
  endfunction : rd_mux

  // i2c slave: sda is open drain, oe high pulls it low
  dlsp_pkg::dlsp_i2c_e st_q;
  logic [3:0] bit_q;
  logic [7:0] sh_q, tx_q, ptr_q;
  logic       rw_q, mnack_q;
  logic [7:0] rd_byte;

  // read byte at the pointer; a process so that register changes are seen too
  always_comb begin
    rd_byte = rd_mux(ptr_q);
  end

  always_ff @(posedge CLK) begin
    wr_en <= 1'b0;
    if (!RST_N) begin
      st_q    <= dlsp_pkg::I2C_IDLE;
      bit_q   <= 4'h0;
      sh_q    <= 8'h00;
      tx_q    <= 8'h00;
      ptr_q   <= 8'h00;
      rw_q    <= 1'b0;
      mnack_q <= 1'b0;
      SDA_OE  <= 1'b0;
      wr_addr <= 8'h00;
      wr_data <= 8'h00;
    end else if (i2c_stop) begin
      st_q   <= dlsp_pkg::I2C_IDLE;
      SDA_OE <= 1'b0;
    end else if (i2c_start) begin
      st_q   <= dlsp_pkg::I2C_ADDR;
      bit_q  <= 4'hf;                                         // first scl fall is no bit edge
      SDA_OE <= 1'b0;
    end else if (scl_rise && st_q != dlsp_pkg::I2C_IDLE) begin
      if (bit_q != 4'h8) begin
        sh_q <= {sh_q[6:0], sda};
      end else if (st_q == dlsp_pkg::I2C_RD) begin
        mnack_q <= sda;
      end
    end else if (scl_fall && st_q != dlsp_pkg::I2C_IDLE) begin
      if (bit_q == 4'h7) begin
        bit_q  <= 4'h8;
        SDA_OE <= 1'b1;
        case (st_q)
          dlsp_pkg::I2C_ADDR: begin
            rw_q <= sh_q[0];
            if (sh_q[7:1] != `DLSP_I2C_ADDR) begin
              st_q   <= dlsp_pkg::I2C_IDLE;
              SDA_OE <= 1'b0;
            end
          end
          dlsp_pkg::I2C_REG: ptr_q <= sh_q;
          dlsp_pkg::I2C_WR: begin
            wr_en   <= 1'b1;
            wr_addr <= ptr_q;
            wr_data <= sh_q;
            ptr_q   <= ptr_q + 8'h01;
          end
          default: SDA_OE <= 1'b0;                            // master acks reads
        endcase
      end else if (bit_q == 4'h8) begin
        bit_q <= 4'h0;
        case (st_q)
          dlsp_pkg::I2C_ADDR: st_q <= rw_q ? dlsp_pkg::I2C_RD : dlsp_pkg::I2C_REG;
          dlsp_pkg::I2C_REG:  st_q <= dlsp_pkg::I2C_WR;
          dlsp_pkg::I2C_WR:   st_q <= dlsp_pkg::I2C_WR;
          default:            st_q <= st_q;
        endcase
        if ((st_q == dlsp_pkg::I2C_ADDR && rw_q) ||
            (st_q == dlsp_pkg::I2C_RD && !mnack_q)) begin
          tx_q   <= {rd_byte[6:0], 1'b0};
          SDA_OE <= ~rd_byte[7];
          ptr_q  <= ptr_q + 8'h01;
        end else if (st_q == dlsp_pkg::I2C_RD) begin
          st_q   <= dlsp_pkg::I2C_IDLE;                       // master nack ends read
          SDA_OE <= 1'b0;
        end else begin
          SDA_OE <= 1'b0;
        end
      end else begin
        bit_q <= bit_q + 4'h1;
        if (st_q == dlsp_pkg::I2C_RD) begin
          SDA_OE <= ~tx_q[7];
          tx_q   <= {tx_q[6:0], 1'b0};
        end
      end
    end
  end

  // lock detect on sampled link clock edges; no reference clock used
  logic [7:0] gap_q, good_q;
  always_ff @(posedge CLK) begin
    if (!run) begin
      gap_q  <= 8'h00;
      good_q <= 8'h00;
      lock_q <= 1'b0;
    end else if (lclk_rise) begin
      gap_q <= 8'h00;
      if (good_q != `DLSP_LOCK_EDGES) begin
        good_q <= good_q + 8'h01;
      end else begin
        lock_q <= 1'b1;
      end
    end else if (gap_q == 8'(`DLSP_LOCK_GAP_CYC)) begin
      good_q <= 8'h00;
      lock_q <= 1'b0;
    end else begin
      gap_q <= gap_q + 8'h01;
    end
  end

  // forward symbol assembly, one bit per link clock rising edge
  dlsp_pkg::dlsp_sym_t sym_q;
  logic [5:0]          sym_cnt_q;
  logic                push_q;
  always_ff @(posedge CLK) begin
    push_q <= 1'b0;
    if (!run || !lock_q) begin
      sym_cnt_q <= 6'h00;
      sym_q     <= '0;
    end else if (lclk_rise) begin
      sym_q <= {sym_q[`DLSP_SYM_BITS-2:0], ldat};
      if (sym_cnt_q == `DLSP_SYM_CNT_LAST) begin
        sym_cnt_q <= 6'h00;
        push_q    <= 1'b1;
      end else begin
        sym_cnt_q <= sym_cnt_q + 6'h01;
      end
    end
  end

  // two-entry buffer: output stage plus skid entry
  dlsp_pkg::dlsp_sym_t skid_q;
  logic                skid_v_q, out_v_q, pass_valid;
  logic                fwd_en, take, out_v_d;

  // pop only on a handshake the receiver saw, so valid and data never part
  assign fwd_en  = lock_q & out_cfg_q[`DLSP_OUT_EN_BIT] & out_cfg_q[`DLSP_OUTPUT_SLEEP_STATE_SEL_BIT];
  assign take    = (FWD_READY & FWD_VALID) | ~out_v_q;
  assign out_v_d = take ? (skid_v_q | push_q) : out_v_q;

  always_ff @(posedge CLK) begin
    if (!run) begin
      out_v_q   <= 1'b0;
      FWD_VALID <= 1'b0;
      skid_v_q  <= 1'b0;
      skid_q    <= '0;
      FWD_DATA  <= '0;
      ovf_q     <= 1'b0;
    end else begin
      FWD_VALID <= out_v_d & fwd_en;
      if (take) begin
        if (skid_v_q) begin
          FWD_DATA <= skid_q;
          out_v_q  <= 1'b1;
          skid_v_q <= push_q;
          if (push_q) begin
            skid_q <= sym_q;
          end
        end else begin
          out_v_q <= push_q;
          if (push_q) begin
            FWD_DATA <= sym_q;
          end
        end
      end else if (push_q) begin
        if (skid_v_q) begin
          ovf_q <= 1'b1;                                      // word dropped, both full
        end else begin
          skid_q   <= sym_q;
          skid_v_q <= 1'b1;
        end
      end
    end
  end

  // remote interrupt: falling edge arms, release of the pin disarms
  always_ff @(posedge CLK) begin
    if (!run) begin
      irq_pend_q <= 1'b0;
    end else if (irq_q && !irq_n) begin
      irq_pend_q <= 1'b1;
    end else if (irq_n) begin
      irq_pend_q <= 1'b0;
    end
  end

  // back-channel bit timer; high-speed bit overrides the divider
  logic [4:0] bc_div_q;
  logic [4:0] bc_period;
  logic       bc_tick;
  assign bc_period = bc_cfg_q[`DLSP_BC_HS_BIT]   ? 5'(`DLSP_BC_20M_CYC) :
                     bc_cfg_q[`DLSP_BC_DIV2_BIT] ? 5'(`DLSP_BC_10M_CYC) :
                                                   5'(`DLSP_BC_5M_CYC);
  assign bc_tick = (bc_div_q == bc_period - 5'h01);
  always_ff @(posedge CLK) begin
    if (!run || bc_tick) begin
      bc_div_q <= 5'h00;
    end else begin
      bc_div_q <= bc_div_q + 5'h01;
    end
  end

  // back-channel frame: start, irq, gpio, i2c bit, crc, stop
  logic [`DLSP_BC_FRAME_BITS-1:0] bc_sh_q;
  logic [3:0]                     bc_cnt_q;
  logic [5:0]                     bc_pay;
  assign bc_pay = {irq_pend_q & irq_cfg_q[`DLSP_IRQ_FWD_EN_BIT], bcg_sync_q, sda};
  always_ff @(posedge CLK) begin
    if (!run) begin
      bc_sh_q  <= '0;
      bc_cnt_q <= 4'h0;
      BC_TX    <= 1'b0;
    end else if (bc_tick) begin
      if (bc_cnt_q == `DLSP_BC_CNT_LAST) begin
        bc_cnt_q <= 4'h0;
        BC_TX    <= 1'b1;
        bc_sh_q  <= {bc_pay, crc4(bc_pay), 1'b0, 1'b0};
      end else begin
        bc_cnt_q <= bc_cnt_q + 4'h1;
        BC_TX    <= bc_sh_q[`DLSP_BC_FRAME_BITS-1];
        bc_sh_q  <= {bc_sh_q[`DLSP_BC_FRAME_BITS-2:0], 1'b0};
      end
    end
  end

  // output state decode from power-down pin, enable and sleep select
  logic output_enable_bit, oss;
  assign output_enable_bit        = out_cfg_q[`DLSP_OUT_EN_BIT];
  assign oss        = out_cfg_q[`DLSP_OUTPUT_SLEEP_STATE_SEL_BIT];
  assign pass_valid = lock_q & ~ovf_q;
  always_ff @(posedge CLK) begin
    if (!run) begin
      {LOCK, LOCK_OE, PASS, PASS_OE, CSI_HS_ZERO, CSI_OE} <= 6'h00;
      D_GPIO    <= 4'h0;
      D_GPIO_OE <= 4'h0;
    end else begin
      LOCK      <= lock_q;
      LOCK_OE   <= 1'b1;
      D_GPIO    <= FWD_DATA[3:0];
      D_GPIO_OE <= (oss && !output_enable_bit) || !dual ? 4'h0 : port_gpio_q[0][3:0];
      case ({output_enable_bit, oss})
        2'b01: begin
          {PASS, PASS_OE, CSI_HS_ZERO, CSI_OE} <= 4'h0;
        end
        2'b11: begin
          PASS_OE     <= 1'b1;
          CSI_OE      <= 1'b1;
          if (lock_q) begin
            PASS        <= pass_valid;
            CSI_HS_ZERO <= 1'b0;
          end else begin
            CSI_HS_ZERO <= 1'b1;                              // pass keeps last value
          end
        end
        default: begin
          {PASS, PASS_OE, CSI_HS_ZERO, CSI_OE} <= 4'h7;
        end
      endcase
    end
  end

endmodule : dlsp_top

// [dlsp_consts.svh]
`ifndef DLSP_CONSTS_SVH
`define DLSP_CONSTS_SVH

// register offsets
`define DLSP_REG_OUT_CFG      8'h02
`define DLSP_REG_STATUS       8'h1c
`define DLSP_REG_PORT_GPIO    8'h1d
`define DLSP_REG_BC_CFG       8'h23
`define DLSP_REG_PORT_SEL     8'h34
`define DLSP_REG_IRQ_CFG      8'h35

// field positions
`define DLSP_OUT_EN_BIT       7
`define DLSP_OUTPUT_SLEEP_STATE_SEL_BIT      4
`define DLSP_BC_DIV2_BIT      6
`define DLSP_BC_HS_BIT        4
`define DLSP_FIRST_PORT_BIT   0
`define DLSP_SECOND_PORT_BIT  1
`define DLSP_IRQ_FWD_EN_BIT   0

// reset values
`define DLSP_OUT_CFG_RST      8'h90
`define DLSP_PORT_SEL_RST     8'h01
`define DLSP_PORT_GPIO_RST    8'h0f
`define DLSP_BC_CFG_RST       8'h00
`define DLSP_IRQ_CFG_RST      8'h00

// i2c slave address, value is arbitrary
`define DLSP_I2C_ADDR         7'h2c

// forward symbol and back-channel frame
`define DLSP_SYM_BITS         35
`define DLSP_SYM_CNT_LAST     6'd34
`define DLSP_BC_FRAME_BITS    12
`define DLSP_BC_CNT_LAST      4'd11

// recovered clock and line rate limits in MHz / Mbps
`define DLSP_CLK1_MIN_MHZ     25
`define DLSP_CLK1_MAX_MHZ     96
`define DLSP_CLK2_MIN_MHZ     50
`define DLSP_CLK2_MAX_MHZ     170
`define DLSP_LINE1_MAX_MBPS   3360
`define DLSP_LINE2_MAX_MBPS   2975
`define DLSP_LINE_MIN_MBPS    875

// timing
`define DLSP_CLK_PERIOD_NS    10
`define DLSP_LOCK_GAP_NS      400
`define DLSP_LOCK_GAP_CYC     (`DLSP_LOCK_GAP_NS / `DLSP_CLK_PERIOD_NS)
`define DLSP_LOCK_EDGES       8'd64
`define DLSP_BC_5M_NS         200
`define DLSP_BC_10M_NS        100
`define DLSP_BC_20M_NS        50
`define DLSP_BC_5M_CYC        (`DLSP_BC_5M_NS / `DLSP_CLK_PERIOD_NS)
`define DLSP_BC_10M_CYC       (`DLSP_BC_10M_NS / `DLSP_CLK_PERIOD_NS)
`define DLSP_BC_20M_CYC       (`DLSP_BC_20M_NS / `DLSP_CLK_PERIOD_NS)

`endif

// [dlsp_pkg.sv]
package dlsp_pkg;
  typedef enum logic [4:0] {
    I2C_IDLE = 5'h01,
    I2C_ADDR = 5'h02,
    I2C_REG  = 5'h04,
    I2C_WR   = 5'h08,
    I2C_RD   = 5'h10
  } dlsp_i2c_e;
  typedef logic [34:0] dlsp_sym_t;
endpackage : dlsp_pkg

// [dlsp_monitor.sv]
`timescale 1ns/100ps
module dlsp_monitor (
  input wire logic                CLK,
  input wire logic                RST_N,
  input wire logic                POWER_DOWN_N,
  input wire logic                DUAL_LANE,
  input wire logic                LINK_CLK,
  input wire logic                BC_TX,
  input wire logic                LOCK,
  input wire logic                LOCK_OE,
  input wire logic                PASS,
  input wire logic                PASS_OE,
  input wire logic [3:0]          D_GPIO_OE,
  input wire logic                CSI_OE,
  input wire dlsp_pkg::dlsp_sym_t FWD_DATA,
  input wire logic                FWD_VALID,
  input wire logic                FWD_READY
);
  logic       lclk_q;
  logic [7:0] gap_q;
  logic [7:0] edges_q;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);
  // raw link edges lead the design's synced copy, so the counts only err high
  always_ff @(posedge CLK) begin
    lclk_q <= LINK_CLK;
  end
  always_ff @(posedge CLK) begin
    if (!RST_N || (LINK_CLK && !lclk_q)) gap_q <= 8'h00;
    else if (gap_q != 8'hff) gap_q <= gap_q + 8'h01;
  end
  always_ff @(posedge CLK) begin
    if (!RST_N || !POWER_DOWN_N) edges_q <= 8'h00;
    else if (LINK_CLK && !lclk_q) edges_q <= (gap_q > 8'd40) ? 8'h01 : edges_q + {7'h0, edges_q != 8'hff};
    else if (gap_q > 8'd40) edges_q <= 8'h00;
  end
  a_pd_floats: assert property (
    !POWER_DOWN_N [*4] |-> !LOCK_OE && !PASS_OE && !CSI_OE && D_GPIO_OE == 4'h0)
    else $error("output driven while powered down");
  a_lock_driven: assert property (
    POWER_DOWN_N [*8] |-> LOCK_OE) else $error("lock not driven while powered");
  a_lock_edges: assert property (
    $rose(LOCK) |-> edges_q >= 8'd65) else $error("lock rose too early");
  a_lock_gap: assert property (
    gap_q >= 8'd50 |-> !LOCK) else $error("lock held across a link gap");
  a_valid_lock: assert property (
    FWD_VALID |-> LOCK) else $error("word offered while unlocked");
  a_word_hold: assert property (
    FWD_VALID && !FWD_READY |=> FWD_VALID && $stable(FWD_DATA))
    else $error("stalled word changed or dropped");
  a_pass_rise: assert property (
    $rose(PASS) |-> LOCK) else $error("pass rose while unlocked");
  a_dgpio_lane: assert property (
    !DUAL_LANE [*6] |-> D_GPIO_OE == 4'h0) else $error("fast gpio driven in single lane");
  // power-down clears the line in mid bit, so it ends any check in flight
  a_bc_bit: assert property (
    disable iff (!RST_N || !POWER_DOWN_N)
    $changed(BC_TX) |=> $stable(BC_TX) [*4]) else $error("back channel bit too short");
endmodule : dlsp_monitor

bind dlsp_top dlsp_monitor dlsp_monitor_i (
  .CLK(CLK), .RST_N(RST_N), .POWER_DOWN_N(POWER_DOWN_N), .DUAL_LANE(DUAL_LANE),
  .LINK_CLK(LINK_CLK), .BC_TX(BC_TX), .LOCK(LOCK), .LOCK_OE(LOCK_OE), .PASS(PASS),
  .PASS_OE(PASS_OE), .D_GPIO_OE(D_GPIO_OE), .CSI_OE(CSI_OE), .FWD_DATA(FWD_DATA),
  .FWD_VALID(FWD_VALID), .FWD_READY(FWD_READY));

// [dlsp_ser_model.sv]
`timescale 1ns/100ps
module dlsp_ser_model (
  input  wire logic run,
  output logic      link_clk,
  output logic      link_data
);
  // one bit per link clock, random payload from the first falling edge, no training
  initial begin
    link_clk = 1'b0;
    link_data = 1'b0;
    #3;
    forever begin
      #80;
      if (run) begin
        link_clk = ~link_clk;
        if (!link_clk) link_data = 1'($urandom_range(1));
      end else begin
        link_clk = 1'b0;
        // idle line toggles so a stale bit never passes for data
        link_data = ~link_data;
      end
    end
  end
endmodule : dlsp_ser_model

// [tb_top.sv]
`timescale 1ns/100ps
`include "dlsp_consts.svh"
module tb_top;
  logic clk = 1'b0, rst_n = 1'b0, pdn = 1'b1, strap = 1'b0, dual = 1'b1, run = 1'b0;
  logic irq_n = 1'b1, scl = 1'b1, sda_m = 1'b1, ready = 1'b1, stall = 1'b0;
  logic [3:0] gpio = 4'h5;
  logic sda_oe, bc_tx, lock, lock_oe, pass, pass_oe, csi_z, csi_oe, fwd_valid, lclk, ldata;
  logic [3:0] dg, dg_oe;
  logic [7:0] q, sel, ocfg, bcc, icfg, cp[2];
  logic [7:0] regs[5] = '{8'h02, 8'h34, 8'h1d, 8'h23, 8'h35};
  logic [7:0] ocs[3] = '{8'h10, 8'h00, 8'h90};
  logic [7:0] bcs[4] = '{8'h00, 8'h40, 8'h10, 8'h50};
  int bts[4] = '{`DLSP_BC_5M_CYC, `DLSP_BC_10M_CYC, `DLSP_BC_20M_CYC, `DLSP_BC_20M_CYC};
  dlsp_pkg::dlsp_sym_t fwd_data, w, last, eq[$];
  int n_mismatch = 0, compares = 0, nb = 0;
  wire sda = sda_m & ~sda_oe;

  always #5 clk = ~clk;

  dlsp_top dlsp_top_i (.CLK(clk), .RST_N(rst_n), .POWER_DOWN_N(pdn), .STRAP_SELECT_B(strap),
    .DUAL_LANE(dual), .LINK_CLK(lclk), .LINK_DATA(ldata), .REMOTE_IRQ_IN_N(irq_n),
    .BC_GPIO_IN(gpio), .SCL_IN(scl), .SDA_IN(sda), .SDA_OE(sda_oe), .BC_TX(bc_tx),
    .LOCK(lock), .LOCK_OE(lock_oe), .PASS(pass), .PASS_OE(pass_oe), .D_GPIO(dg),
    .D_GPIO_OE(dg_oe), .CSI_HS_ZERO(csi_z), .CSI_OE(csi_oe), .FWD_DATA(fwd_data),
    .FWD_VALID(fwd_valid), .FWD_READY(ready));
  dlsp_ser_model dlsp_ser_model_i (.run(run), .link_clk(lclk), .link_data(ldata));

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_byte
  task automatic chk_word(input logic [34:0] got, input logic [34:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_word
  task automatic print_verdict;
    if (n_mismatch == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : print_verdict
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick

  // bench model of the word stream: first bit after lock lands in the top bit
  always @(posedge lclk) begin
    if (lock !== 1'b1) nb = 0;
    else begin
      w = {w[33:0], ldata};
      nb++;
      if (nb == `DLSP_SYM_BITS) begin
        if (eq.size() < 2) eq.push_back(w);
        nb = 0;
      end
    end
  end
  always @(posedge clk) begin
    if (fwd_valid === 1'b1 && ready === 1'b1) begin
      last = eq.size() ? eq.pop_front() : 'x;
      chk_word(fwd_data, last);
    end
    ready <= stall ? 1'b0 : (($urandom % 4) != 0);
  end

  task automatic do_reset(input logic s);
    strap <= s;
    rst_n <= 1'b0;
    tick(5);
    rst_n <= 1'b1;
    tick(6);
    sel = 8'h01;
    ocfg = 8'h90;
    icfg = 8'h00;
    cp[0] = 8'h0f;
    cp[1] = 8'h0f;
    bcc = {3'b000, s, 4'h0};
  endtask : do_reset
  // i2c master; data moves only while scl is low
  task automatic ibit(input logic b, output logic r);
    sda_m <= b;
    tick(8);
    scl <= 1'b1;
    tick(8);
    r = sda;
    scl <= 1'b0;
    tick(1);
  endtask : ibit
  task automatic ibyte(input logic [7:0] b, output logic [7:0] r);
    for (int i = 7; i >= 0; i--) ibit(b[i], r[i]);
  endtask : ibyte
  task automatic start_c;
    sda_m <= 1'b1;
    tick(4);
    scl <= 1'b1;
    tick(8);
    sda_m <= 1'b0;
    tick(8);
    scl <= 1'b0;
    tick(4);
  endtask : start_c
  task automatic stop_c;
    sda_m <= 1'b0;
    tick(4);
    scl <= 1'b1;
    tick(8);
    sda_m <= 1'b1;
    tick(12);
  endtask : stop_c
  task automatic i2c(input logic [6:0] dev, input logic [7:0] a, input logic [7:0] d,
                     input logic rnw, output logic [7:0] r);
    logic [7:0] t;
    logic k;
    start_c;
    ibyte({dev, 1'b0}, t);
    ibit(1'b1, k);
    ibyte(a, t);
    ibit(1'b1, k);
    if (rnw) begin
      stop_c;
      start_c;
      ibyte({dev, 1'b1}, t);
      ibit(1'b1, k);
    end
    ibyte(rnw ? 8'hff : d, r);
    ibit(1'b1, k);
    stop_c;
  endtask : i2c
  task automatic mwr(input logic [7:0] a, input logic [7:0] d);
    i2c(`DLSP_I2C_ADDR, a, d, 1'b0, q);
    case (a)
      `DLSP_REG_OUT_CFG: ocfg = d;
      `DLSP_REG_PORT_SEL: sel = d;
      `DLSP_REG_BC_CFG: bcc = d;
      `DLSP_REG_IRQ_CFG: icfg = d;
      `DLSP_REG_PORT_GPIO: begin
        if (sel[0]) cp[0] = d;
        if (sel[1]) cp[1] = d;
      end
      default: ;
    endcase
  endtask : mwr
  function automatic logic [7:0] mexp(input logic [7:0] a);
    case (a)
      `DLSP_REG_OUT_CFG: return ocfg;
      `DLSP_REG_PORT_SEL: return sel;
      `DLSP_REG_BC_CFG: return bcc;
      `DLSP_REG_IRQ_CFG: return icfg;
      `DLSP_REG_PORT_GPIO: return sel[1] ? cp[1] : cp[0];
      default: return 8'h00;
    endcase
  endfunction : mexp
  task automatic mrd(input logic [7:0] a);
    i2c(`DLSP_I2C_ADDR, a, 8'h00, 1'b1, q);
    chk_byte(q, mexp(a));
  endtask : mrd
  task automatic st(input logic [3:0] m, input logic [3:0] e);
    i2c(`DLSP_I2C_ADDR, `DLSP_REG_STATUS, 8'h00, 1'b1, q);
    chk_byte({4'h0, q[3:0] & m}, {4'h0, e});
  endtask : st
  // output state for the sleep-float setting versus all other settings, link static
  task automatic outs;
    logic f;
    f = !ocfg[7] && ocfg[4];
    chk_word(35'({lock, lock_oe, pass_oe, csi_oe, csi_z & csi_oe, dg_oe}),
             35'({2'b01, !f, !f, !f, (f || !dual) ? 4'h0 : cp[0][3:0]}));
  endtask : outs
  // every back-channel run must be a whole number of bit times
  task automatic bc_rate(input logic [7:0] c, input int t);
    logic l;
    int n;
    bit seen;
    gpio <= 4'($urandom);
    mwr(`DLSP_REG_BC_CFG, c);
    tick(300);
    l = bc_tx;
    n = 0;
    seen = 0;
    repeat (500) begin
      @(posedge clk);
      n++;
      if (bc_tx !== l) begin
        if (seen) chk_byte(8'(n % t), 8'h00);
        seen = 1;
        n = 0;
        l = bc_tx;
      end
    end
  endtask : bc_rate

  initial begin
    void'($urandom(16664));
    do_reset(1'b0);
    foreach (regs[i]) mrd(regs[i]);
    for (int i = 0; i < 6; i++) begin
      mwr(`DLSP_REG_PORT_SEL, 8'(i % 3 + 1));
      mrd(`DLSP_REG_PORT_GPIO);
      mwr(`DLSP_REG_PORT_GPIO, 8'($urandom));
    end
    mwr(`DLSP_REG_PORT_SEL, 8'h01);
    mrd(`DLSP_REG_PORT_GPIO);
    mwr(8'h50, 8'hab);
    mrd(8'h50);
    i2c(7'h2d, `DLSP_REG_OUT_CFG, 8'h00, 1'b1, q);
    chk_byte(q, 8'hff);
    foreach (ocs[i]) begin
      mwr(`DLSP_REG_OUT_CFG, ocs[i]);
      for (int d = 1; d >= 0; d--) begin
        dual <= d[0];
        tick(10);
        outs;
      end
    end
    dual <= 1'b1;
    foreach (bcs[i]) bc_rate(bcs[i], bts[i]);
    mwr(`DLSP_REG_IRQ_CFG, 8'h01);
    irq_n <= 1'b0;
    tick(10);
    st(4'h6, 4'h6);
    irq_n <= 1'b1;
    tick(10);
    st(4'h4, 4'h0);
    run <= 1'b1;
    for (int k = 0; k < 3000 && lock !== 1'b1; k++) tick(1);
    chk_byte({7'h0, lock}, 8'h01);
    tick(3000);
    st(4'h1, 4'h1);
    chk_byte({7'h0, pass}, 8'h01);
    stall <= 1'b1;
    tick(2000);
    st(4'h8, 4'h8);
    stall <= 1'b0;
    tick(1200);
    run <= 1'b0;
    tick(60);
    chk_byte({7'h0, lock}, 8'h00);
    chk_byte(8'(eq.size()), 8'h00);
    chk_byte({4'h0, dg}, {4'h0, last[3:0]});
    pdn <= 1'b0;
    tick(6);
    chk_word(35'({lock_oe, pass_oe, csi_oe, dg_oe}), 35'h0);
    pdn <= 1'b1;
    tick(10);
    chk_word(35'({lock, lock_oe}), 35'h1);
    do_reset(1'b1);
    mrd(`DLSP_REG_BC_CFG);
    print_verdict;
  end

  initial begin
    tick(90000);
    n_mismatch++;
    print_verdict;
  end
endmodule : tb_top
